// [rtl/sms_pkg.sv]
package sms_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int SMS_BYTE_W = 8;
  localparam int SMS_ADDR_W = 3;
  localparam int SMS_CMD_ADDR_LSB = 5;
  localparam int SMS_CMD_DIR_BIT = 4;
  // Address bits as they sit in the shifter after six samples
  localparam int SMS_LIVE_ADDR_LSB = 3;
  localparam logic SMS_DIR_READ = 1'b1;
  localparam logic [2:0] SMS_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  localparam int SMS_ST_TXE_BIT = 3;
  localparam int SMS_ST_RXF_BIT = 2;
  localparam int SMS_ST_ACK_BIT = 1;
  localparam logic [7:0] SMS_ST_DRIVE_MASK = 8'h0E;
  localparam logic [7:0] SMS_ALL_DRIVE = 8'hFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SMS_DATA_RST = 8'h00;
  localparam logic [2:0] SMS_CNT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Modes and byte slots
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMS_FULL_DUPLEX,
    SMS_HALF_4PIN,
    SMS_HALF_3PIN,
    SMS_UNMANAGED
  } sms_mode_e;

  typedef enum logic [2:0] {
    SMS_SLOT_CMD,
    SMS_SLOT_STAT,
    SMS_SLOT_WDATA,
    SMS_SLOT_RDATA,
    SMS_SLOT_DEAD
  } sms_slot_e;

endpackage : sms_pkg

// [rtl/sms_drive_if.sv]
interface sms_drive_if;
  logic out_bit;
  logic out_oe;
  logic in_bit;
  logic in_oe;

  modport ctrl (output out_bit, output out_oe, output in_bit, output in_oe);
  modport stage (input out_bit, input out_oe, input in_bit, input in_oe);
endinterface : sms_drive_if

// [rtl/sms_launch.sv]
module sms_launch
  import sms_pkg::*;
(
  // Link timing
  input logic link_clk,
  input logic select_n,
  // Requested pin levels
  sms_drive_if.stage drv,
  // Pin drivers
  output logic serial_out,
  output logic serial_out_oe,
  output logic serial_in_out,
  output logic serial_in_oe
);

  logic out_bit_reg, out_bit_next;
  logic out_oe_reg, out_oe_next;
  logic in_bit_reg, in_bit_next;
  logic in_oe_reg, in_oe_next;

  // ----------------------------------------------------------------
  // Launch edge: opposite to the sampling edge
  // ----------------------------------------------------------------
  always_comb begin
    out_bit_next = drv.out_bit;
    out_oe_next = drv.out_oe;
    in_bit_next = drv.in_bit;
    in_oe_next = drv.in_oe;
  end

  // Deselect releases both lines at once, whatever the clock does
  always_ff @(negedge link_clk or posedge select_n) begin
    if (select_n) begin
      out_bit_reg <= 1'b0;
      out_oe_reg <= 1'b0;
      in_bit_reg <= 1'b0;
      in_oe_reg <= 1'b0;
    end else begin
      out_bit_reg <= out_bit_next;
      out_oe_reg <= out_oe_next;
      in_bit_reg <= in_bit_next;
      in_oe_reg <= in_oe_next;
    end
  end

  assign serial_out = out_bit_reg;
  assign serial_out_oe = out_oe_reg;
  assign serial_in_out = in_bit_reg;
  assign serial_in_oe = in_oe_reg;

endmodule : sms_launch

// [rtl/sms_slave.sv]
module sms_slave
  import sms_pkg::*;
#(
  parameter int ADDR_W = SMS_ADDR_W
) (
  // System
  input logic clock,
  input logic rst,
  input logic clock_enable,
  // Configuration
  input sms_mode_e mode_sel,
  input logic [ADDR_W-1:0] own_address,
  input logic clock_polarity,
  input logic clock_phase,
  // CPU transmit side
  input logic [SMS_BYTE_W-1:0] tx_data_in,
  input logic tx_write,
  // CPU receive side
  input logic rx_read,
  output logic [SMS_BYTE_W-1:0] rx_data,
  // Status
  output logic transmit_empty_flag,
  output logic receive_full_flag,
  output logic rx_overrun,
  output logic link_busy,
  // Link pins
  input logic slave_a_serial_clock,
  input logic slave_a_select_n,
  input logic slave_a_serial_in,
  output logic slave_a_serial_in_out,
  output logic slave_a_serial_in_oe,
  output logic slave_a_serial_out,
  output logic slave_a_serial_out_oe
);

  if (ADDR_W != SMS_ADDR_W) begin : g_addr_check
    $error("sms_slave: command byte carries exactly three address bits");
  end

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(logic [ADDR_W-1:0] a, logic [ADDR_W-1:0] own);
    return a == own;
  endfunction : addr_hit

  function automatic sms_slot_e slot_after(sms_mode_e m, sms_slot_e s, logic rd,
                                           logic ack);
    sms_slot_e r;
    r = s;
    unique case (s)
      SMS_SLOT_CMD: begin
        if (!ack) begin
          r = SMS_SLOT_DEAD;
        end else if (m == SMS_HALF_3PIN) begin
          r = SMS_SLOT_STAT;
        end else begin
          r = rd ? SMS_SLOT_RDATA : SMS_SLOT_WDATA;
        end
      end
      SMS_SLOT_STAT: r = rd ? SMS_SLOT_RDATA : SMS_SLOT_WDATA;
      SMS_SLOT_RDATA: r = (m == SMS_HALF_4PIN) ? SMS_SLOT_RDATA : SMS_SLOT_STAT;
      SMS_SLOT_WDATA: r = (m == SMS_HALF_3PIN) ? SMS_SLOT_STAT : SMS_SLOT_WDATA;
      SMS_SLOT_DEAD: r = SMS_SLOT_DEAD;
      default: r = SMS_SLOT_DEAD;
    endcase
    return r;
  endfunction : slot_after

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // Configuration is quasi-static: change it only while deselected.
  logic eff_phase;
  logic link_clk;
  assign eff_phase = (mode_sel == SMS_UNMANAGED) ? clock_phase : 1'b1;
  // Rising edge of link_clk is always the sampling edge
  assign link_clk = slave_a_serial_clock ^ clock_polarity ^ eff_phase;

  // ----------------------------------------------------------------
  // System side state
  // ----------------------------------------------------------------
  logic [SMS_BYTE_W-1:0] tx_data_reg, tx_data_next;
  logic tx_empty_reg, tx_empty_next;
  logic [SMS_BYTE_W-1:0] rx_data_reg, rx_data_next;
  logic rx_full_reg, rx_full_next;
  logic overrun_reg, overrun_next;
  logic busy_reg, busy_next;
  logic sel_meta_reg, sel_sync_reg;
  logic push_meta_reg, push_sync_reg, push_last_reg;
  logic cons_meta_reg, cons_sync_reg, cons_last_reg;
  logic push_evt, cons_evt;

  // ----------------------------------------------------------------
  // Link side state
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [SMS_BYTE_W-1:0] sh_reg, sh_next;
  sms_slot_e slot_reg, slot_next;
  logic rd_reg, rd_next;
  logic ack_reg, ack_next;
  // Toggles and the received word survive deselect, so no select reset
  logic [SMS_BYTE_W-1:0] rx_word_reg = SMS_DATA_RST;
  logic [SMS_BYTE_W-1:0] rx_word_next;
  logic push_tgl_reg = 1'b0;
  logic push_tgl_next;
  logic cons_tgl_reg = 1'b0;
  logic cons_tgl_next;
  logic txe_meta_reg = 1'b1;
  logic txe_sync_reg = 1'b1;
  logic rxf_meta_reg = 1'b0;
  logic rxf_sync_reg = 1'b0;
  logic byte_done, rd_now, ack_now, live_ack;
  logic [2:0] idx;
  logic [SMS_BYTE_W-1:0] status;
  logic st_bit, st_oe, data_bit;

  sms_drive_if drv ();

  // ----------------------------------------------------------------
  // Link side next state
  // ----------------------------------------------------------------
  always_comb begin
    sh_next = {sh_reg[SMS_BYTE_W-2:0], slave_a_serial_in};
    bit_cnt_next = bit_cnt_reg + 3'h1;
    byte_done = (bit_cnt_reg == SMS_LAST_BIT);
    rd_now = (slot_reg == SMS_SLOT_CMD) ? (sh_next[SMS_CMD_DIR_BIT] == SMS_DIR_READ)
                                        : rd_reg;
    ack_now = (slot_reg == SMS_SLOT_CMD)
              ? addr_hit(sh_next[SMS_CMD_ADDR_LSB +: SMS_ADDR_W], own_address)
              : ack_reg;
    slot_next = slot_reg;
    rd_next = rd_reg;
    ack_next = ack_reg;
    rx_word_next = rx_word_reg;
    push_tgl_next = push_tgl_reg;
    cons_tgl_next = cons_tgl_reg;
    if (byte_done) begin
      if (mode_sel == SMS_UNMANAGED) begin
        rx_word_next = sh_next;
        push_tgl_next = ~push_tgl_reg;
        cons_tgl_next = cons_tgl_reg ^ ~txe_sync_reg;
      end else begin
        slot_next = slot_after(mode_sel, slot_reg, rd_now, ack_now);
        rd_next = rd_now;
        ack_next = ack_now;
        // Write bytes are taken only while status allowed them
        if (slot_reg == SMS_SLOT_WDATA && !rxf_sync_reg) begin
          rx_word_next = sh_next;
          push_tgl_next = ~push_tgl_reg;
        end
        if (slot_reg == SMS_SLOT_RDATA && !txe_sync_reg) begin
          cons_tgl_next = ~cons_tgl_reg;
        end
      end
    end
  end

  always_ff @(posedge link_clk or posedge slave_a_select_n) begin
    if (slave_a_select_n) begin
      bit_cnt_reg <= SMS_CNT_RST;
      sh_reg <= SMS_DATA_RST;
      slot_reg <= SMS_SLOT_CMD;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      sh_reg <= sh_next;
      slot_reg <= slot_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
    end
  end

  always_ff @(posedge link_clk) begin
    rx_word_reg <= rx_word_next;
    push_tgl_reg <= push_tgl_next;
    cons_tgl_reg <= cons_tgl_next;
    txe_meta_reg <= tx_empty_reg;
    txe_sync_reg <= txe_meta_reg;
    rxf_meta_reg <= rx_full_reg;
    rxf_sync_reg <= rxf_meta_reg;
  end

  // ----------------------------------------------------------------
  // Pin drive request
  // ----------------------------------------------------------------
  // tx_data_reg crosses as a held word: it only changes while empty.
  always_comb begin
    idx = ~bit_cnt_reg;
    live_ack = addr_hit(sh_reg[SMS_LIVE_ADDR_LSB +: SMS_ADDR_W], own_address);
    status = SMS_DATA_RST;
    status[SMS_ST_TXE_BIT] = txe_sync_reg;
    status[SMS_ST_RXF_BIT] = rxf_sync_reg;
    status[SMS_ST_ACK_BIT] = (slot_reg == SMS_SLOT_CMD) ? live_ack : ack_reg;
    st_bit = status[idx];
    st_oe = SMS_ST_DRIVE_MASK[idx];
    data_bit = tx_data_reg[idx];
    drv.out_bit = 1'b0;
    drv.out_oe = 1'b0;
    drv.in_bit = 1'b0;
    drv.in_oe = 1'b0;
    unique case (mode_sel)
      SMS_FULL_DUPLEX: begin
        if (slot_reg == SMS_SLOT_RDATA) begin
          drv.out_bit = data_bit;
          drv.out_oe = SMS_ALL_DRIVE[idx];
        end else if (slot_reg != SMS_SLOT_DEAD) begin
          drv.out_bit = st_bit;
          drv.out_oe = st_oe;
        end
      end
      SMS_HALF_4PIN: begin
        if (slot_reg != SMS_SLOT_DEAD) begin
          drv.out_bit = st_bit;
          drv.out_oe = st_oe;
        end
        if (slot_reg == SMS_SLOT_RDATA) begin
          drv.in_bit = data_bit;
          drv.in_oe = SMS_ALL_DRIVE[idx];
        end
      end
      SMS_HALF_3PIN: begin
        if (slot_reg == SMS_SLOT_STAT) begin
          drv.in_bit = st_bit;
          drv.in_oe = st_oe;
        end else if (slot_reg == SMS_SLOT_RDATA) begin
          drv.in_bit = data_bit;
          drv.in_oe = SMS_ALL_DRIVE[idx];
        end
      end
      SMS_UNMANAGED: begin
        drv.out_bit = data_bit;
        drv.out_oe = SMS_ALL_DRIVE[idx];
      end
    endcase
  end

  sms_launch u_launch (
    .link_clk(link_clk),
    .select_n(slave_a_select_n),
    .drv(drv.stage),
    .serial_out(slave_a_serial_out),
    .serial_out_oe(slave_a_serial_out_oe),
    .serial_in_out(slave_a_serial_in_out),
    .serial_in_oe(slave_a_serial_in_oe)
  );

  // ----------------------------------------------------------------
  // System side next state
  // ----------------------------------------------------------------
  assign push_evt = push_sync_reg ^ push_last_reg;
  assign cons_evt = cons_sync_reg ^ cons_last_reg;

  always_comb begin
    tx_data_next = tx_data_reg;
    tx_empty_next = tx_empty_reg;
    if (cons_evt) begin
      tx_empty_next = 1'b1;
    end
    // A write in the consume cycle wins; a write onto full data is ignored
    if (tx_write && (tx_empty_reg || cons_evt)) begin
      tx_data_next = tx_data_in;
      tx_empty_next = 1'b0;
    end
    rx_data_next = rx_data_reg;
    rx_full_next = rx_full_reg;
    overrun_next = overrun_reg;
    if (rx_read) begin
      rx_full_next = 1'b0;
      overrun_next = 1'b0;
    end
    if (push_evt) begin
      rx_data_next = rx_word_reg;
      rx_full_next = 1'b1;
      if (rx_full_reg && !rx_read) begin
        overrun_next = 1'b1;
      end
    end
    busy_next = ~sel_sync_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_data_reg <= SMS_DATA_RST;
      tx_empty_reg <= 1'b1;
      rx_data_reg <= SMS_DATA_RST;
      rx_full_reg <= 1'b0;
      overrun_reg <= 1'b0;
      busy_reg <= 1'b0;
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      // Chains track through reset, so an old toggle is no event; hold reset 3 cycles
      push_meta_reg <= push_tgl_reg;
      push_sync_reg <= push_meta_reg;
      push_last_reg <= push_sync_reg;
      cons_meta_reg <= cons_tgl_reg;
      cons_sync_reg <= cons_meta_reg;
      cons_last_reg <= cons_sync_reg;
    end else if (clock_enable) begin
      tx_data_reg <= tx_data_next;
      tx_empty_reg <= tx_empty_next;
      rx_data_reg <= rx_data_next;
      rx_full_reg <= rx_full_next;
      overrun_reg <= overrun_next;
      busy_reg <= busy_next;
      sel_meta_reg <= slave_a_select_n;
      sel_sync_reg <= sel_meta_reg;
      push_meta_reg <= push_tgl_reg;
      push_sync_reg <= push_meta_reg;
      push_last_reg <= push_sync_reg;
      cons_meta_reg <= cons_tgl_reg;
      cons_sync_reg <= cons_meta_reg;
      cons_last_reg <= cons_sync_reg;
    end
  end

  assign rx_data = rx_data_reg;
  assign transmit_empty_flag = tx_empty_reg;
  assign receive_full_flag = rx_full_reg;
  assign rx_overrun = overrun_reg;
  assign link_busy = busy_reg;

endmodule : sms_slave

// [verif/sms_slave_props.sv]
module sms_chk
  import sms_pkg::*;
(
  // System
  input logic clock,
  input logic rst,
  input logic clock_enable,
  input sms_mode_e mode_sel,
  // CPU side
  input logic tx_write,
  input logic rx_read,
  input logic [SMS_BYTE_W-1:0] rx_data,
  input logic transmit_empty_flag,
  input logic receive_full_flag,
  input logic rx_overrun,
  input logic link_busy,
  // Link
  input logic slave_a_select_n,
  input logic slave_a_serial_in_oe,
  input logic slave_a_serial_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Flags may only rise while a frame is near, never out of nowhere
  logic [3:0] idle_reg;
  logic [3:0] idle_next;
  always_comb begin
    idle_next = idle_reg;
    if (link_busy) idle_next = 4'h0;
    else if (idle_reg != 4'hF) idle_next = idle_reg + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (rst) idle_reg <= 4'hF;
    else idle_reg <= idle_next;
  end

  sequence tx_take_s;
    clock_enable && tx_write && transmit_empty_flag;
  endsequence
  sequence deselect_s;
    $rose(slave_a_select_n);
  endsequence

  reset_val_a: assert property ($fell(rst) |-> transmit_empty_flag &&
    !receive_full_flag && !rx_overrun && !link_busy && rx_data == SMS_DATA_RST)
    else $error("flags wrong after reset");
  tx_take_a: assert property (tx_take_s |=> !transmit_empty_flag)
    else $error("byte not taken");
  rf_hold_a: assert property (receive_full_flag && !(clock_enable && rx_read) |=>
    receive_full_flag) else $error("full flag lost");
  overrun_cause_a: assert property ($rose(rx_overrun) |-> $past(receive_full_flag))
    else $error("overrun while empty");
  te_rise_a: assert property ($rose(transmit_empty_flag) |-> idle_reg < 4'h8)
    else $error("empty flag rose idle");
  rf_rise_a: assert property ($rose(receive_full_flag) |-> idle_reg < 4'h8)
    else $error("full flag rose idle");
  busy_rise_a: assert property ($rose(link_busy) |-> !$past(slave_a_select_n, 2) &&
    !$past(slave_a_select_n)) else $error("busy without select");
  busy_drop_a: assert property (deselect_s |-> ##[1:5] !link_busy)
    else $error("busy stuck");
  oe_idle_a: assert property (slave_a_select_n |-> !slave_a_serial_out_oe &&
    !slave_a_serial_in_oe) else $error("drive while deselected");
  three_pin_a: assert property (mode_sel == SMS_HALF_3PIN |-> !slave_a_serial_out_oe)
    else $error("serial out driven");
  inbus_half_a: assert property (slave_a_serial_in_oe |->
    mode_sel inside {SMS_HALF_4PIN, SMS_HALF_3PIN}) else $error("serial in driven");
  freeze_hold_a: assert property (!clock_enable |=> $stable(transmit_empty_flag) &&
    $stable(receive_full_flag) && $stable(rx_data) && $stable(link_busy))
    else $error("state moved while frozen");
endmodule : sms_chk

bind sms_slave sms_chk sms_chk_inst (.clock, .rst, .clock_enable, .mode_sel, .tx_write,
  .rx_read, .rx_data, .transmit_empty_flag, .receive_full_flag, .rx_overrun, .link_busy,
  .slave_a_select_n, .slave_a_serial_in_oe, .slave_a_serial_out_oe);

// [verif/sms_mst.sv]
module sms_mst (
  // Clock and select
  output logic sclk,
  output logic sel_n,
  // Master data line
  output logic mo,
  // Lines from the slave
  input logic so,
  input logic so_oe,
  input logic si,
  input logic si_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cpha;
  logic [7:0] ro, eo, rs, es;
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    mo = 1'b0;
    cpha = 1'b1;
  end
  task automatic start(input logic cp, input logic ph);
    cpha = ph;
    sclk = cp;
    #62.5 sel_n = 1'b0;
    #62.5;
  endtask : start
  task automatic stop();
    #62.5 sel_n = 1'b1;
    #500;
  endtask : stop
  task automatic grab(input int i);
    ro[i] = so_oe ? so : ~so;
    eo[i] = so_oe;
    rs[i] = si;
    es[i] = si_oe;
  endtask : grab
  // Released line toggles each bit so a stale level never reads as data
  task automatic xfer(input logic [7:0] t, input logic drv, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      if (!cpha) mo = drv ? t[i] : ~mo;
      #62.5 sclk = ~sclk;
      if (cpha) mo = drv ? t[i] : ~mo;
      else grab(i);
      #62.5 sclk = ~sclk;
      if (cpha) grab(i);
    end
  endtask : xfer
endmodule : sms_mst

// [verif/test_spi_slave_multimode.sv]
module test_spi_slave_multimode
  import sms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clock_enable = 1'b1;
  sms_mode_e mode_sel = SMS_FULL_DUPLEX;
  logic [2:0] own_address = 3'h0;
  logic clock_polarity = 1'b1;
  logic clock_phase = 1'b1;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_write = 1'b0;
  logic rx_read = 1'b0;
  logic [7:0] rx_data;
  logic transmit_empty_flag, receive_full_flag, rx_overrun, link_busy, mo;
  logic slave_a_serial_clock, slave_a_select_n, slave_a_serial_in, slave_a_serial_in_out;
  logic slave_a_serial_in_oe, slave_a_serial_out, slave_a_serial_out_oe;
  int failures = 0;
  int num_checks = 0;
  int seed = 27;
  logic [2:0] adr;
  logic [7:0] d, e;
  always #10 clock = ~clock;
  assign slave_a_serial_in = slave_a_serial_in_oe ? slave_a_serial_in_out : mo;
  sms_slave sms_slave_inst (.clock, .rst, .clock_enable, .mode_sel, .own_address,
    .clock_polarity, .clock_phase, .tx_data_in, .tx_write, .rx_read, .rx_data,
    .transmit_empty_flag, .receive_full_flag, .rx_overrun, .link_busy, .slave_a_serial_clock,
    .slave_a_select_n, .slave_a_serial_in, .slave_a_serial_in_out, .slave_a_serial_in_oe,
    .slave_a_serial_out, .slave_a_serial_out_oe);
  sms_mst sms_mst_inst (.sclk(slave_a_serial_clock), .sel_n(slave_a_select_n), .mo(mo),
    .so(slave_a_serial_out), .so_oe(slave_a_serial_out_oe), .si(slave_a_serial_in),
    .si_oe(slave_a_serial_in_oe));

  function automatic logic [7:0] cmd(input logic [2:0] a, input logic rd);
    return {a, rd, 4'h0};
  endfunction : cmd
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic flag(input logic f, input logic exp);
    check({7'h00, f}, {7'h00, exp});
  endtask : flag
  task automatic stat(input logic [7:0] r, input logic [2:0] f);
    check(r & SMS_ST_DRIVE_MASK, {4'h0, f, 1'b0});
  endtask : stat
  task automatic cpu(input logic wr, input logic [7:0] v);
    @(posedge clock);
    tx_data_in <= v;
    tx_write <= wr;
    rx_read <= !wr;
    @(posedge clock);
    tx_write <= 1'b0;
    rx_read <= 1'b0;
    #1;
    if (wr) flag(transmit_empty_flag, 1'b0);
    else flag(receive_full_flag, 1'b0);
  endtask : cpu
  task automatic frame(input sms_mode_e md, input logic [1:0] cm);
    @(posedge clock);
    mode_sel <= md;
    clock_polarity <= cm[1];
    clock_phase <= cm[0];
    own_address <= adr;
    @(posedge clock);
    sms_mst_inst.start(cm[1], cm[0]);
  endtask : frame
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    #200us;
    failures++;
    $display("unexpected at %0t got %h expected %h", $time, 8'h00, 8'h01);
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check({transmit_empty_flag, receive_full_flag, rx_overrun, link_busy, 4'h0}, 8'h80);
    check(rx_data, SMS_DATA_RST);
    adr = $random(seed);
    d = $random(seed);
    frame(SMS_FULL_DUPLEX, 2'b11);
    sms_mst_inst.xfer(cmd(adr, 1'b0), 1'b1, 8);
    sms_mst_inst.xfer(d, 1'b1, 5);
    sms_mst_inst.stop();
    flag(receive_full_flag, 1'b0);
    frame(SMS_FULL_DUPLEX, 2'b01);
    sms_mst_inst.xfer(cmd(adr ^ 3'h5, 1'b0), 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b100);
    sms_mst_inst.xfer(d, 1'b1, 8);
    check(sms_mst_inst.eo, 8'h00);
    sms_mst_inst.stop();
    cpu(1'b0, 8'h00);
    frame(SMS_FULL_DUPLEX, 2'b11);
    sms_mst_inst.xfer(cmd(adr, 1'b0), 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b101);
    check(sms_mst_inst.eo, SMS_ST_DRIVE_MASK);
    sms_mst_inst.xfer(d, 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b101);
    flag(link_busy, 1'b1);
    sms_mst_inst.xfer(~d, 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b111);
    sms_mst_inst.stop();
    check(rx_data, d);
    flag(receive_full_flag, 1'b1);
    cpu(1'b0, 8'h00);
    cpu(1'b1, d);
    frame(SMS_FULL_DUPLEX, 2'b01);
    sms_mst_inst.xfer(cmd(adr, 1'b1), 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b001);
    sms_mst_inst.xfer(8'h00, 1'b1, 8);
    check(sms_mst_inst.ro, d);
    sms_mst_inst.xfer(8'h00, 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b101);
    sms_mst_inst.stop();
    e = $random(seed);
    frame(SMS_HALF_4PIN, 2'b11);
    sms_mst_inst.xfer(cmd(adr, 1'b0), 1'b1, 8);
    stat(sms_mst_inst.ro, 3'b101);
    sms_mst_inst.xfer(e, 1'b1, 8);
    check(sms_mst_inst.eo, SMS_ST_DRIVE_MASK);
    sms_mst_inst.stop();
    check(rx_data, e);
    cpu(1'b0, 8'h00);
    cpu(1'b1, d);
    frame(SMS_HALF_4PIN, 2'b01);
    sms_mst_inst.xfer(cmd(adr, 1'b1), 1'b1, 8);
    sms_mst_inst.xfer(8'h00, 1'b0, 8);
    check(sms_mst_inst.rs, d);
    check(sms_mst_inst.es, SMS_ALL_DRIVE);
    sms_mst_inst.stop();
    cpu(1'b1, e);
    frame(SMS_HALF_3PIN, 2'b11);
    sms_mst_inst.xfer(cmd(adr, 1'b1), 1'b1, 8);
    sms_mst_inst.xfer(8'h00, 1'b0, 8);
    stat(sms_mst_inst.rs, 3'b001);
    check(sms_mst_inst.eo, 8'h00);
    sms_mst_inst.xfer(8'h00, 1'b0, 8);
    check(sms_mst_inst.rs, e);
    sms_mst_inst.stop();
    d = $random(seed);
    frame(SMS_HALF_3PIN, 2'b01);
    sms_mst_inst.xfer(cmd(adr, 1'b0), 1'b1, 8);
    sms_mst_inst.xfer(8'h00, 1'b0, 8);
    stat(sms_mst_inst.rs, 3'b101);
    sms_mst_inst.xfer(d, 1'b1, 8);
    sms_mst_inst.xfer(8'h00, 1'b0, 8);
    stat(sms_mst_inst.rs, 3'b111);
    sms_mst_inst.stop();
    check(rx_data, d);
    cpu(1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      e = $random(seed);
      cpu(1'b1, d);
      frame(SMS_UNMANAGED, k[1:0]);
      sms_mst_inst.xfer(e, 1'b1, 8);
      sms_mst_inst.stop();
      check(rx_data, e);
      flag(rx_overrun, k == 3);
      if (k[0]) check(sms_mst_inst.ro, d);
      if (k != 2) cpu(1'b0, 8'h00);
    end
    @(posedge clock);
    clock_enable <= 1'b0;
    tx_write <= 1'b1;
    repeat (3) @(posedge clock);
    tx_write <= 1'b0;
    clock_enable <= 1'b1;
    #1;
    flag(transmit_empty_flag, 1'b1);
    // Mid-run reset with the receive toggle left odd
    @(posedge clock);
    rst <= 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check({transmit_empty_flag, receive_full_flag, rx_overrun, link_busy, 4'h0}, 8'h80);
    check(rx_data, SMS_DATA_RST);
    results();
  end
endmodule : test_spi_slave_multimode
